/* src/dpll_cfg_pkg.sv */
// Constants for the DPLL limiter and holdover filter configuration bank
package dpll_cfg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int           ADDR_W              = 10;
    localparam int           DATA_W              = 8;
    localparam int           NUM_CH              = 3;
    localparam logic [9:0]   LIMITER_SELECT_ADDR = 10'h2cf;
    localparam logic [9:0]   HOLDOVER_CH0_ADDR   = 10'h2d4;
    localparam logic [9:0]   HOLDOVER_CH1_ADDR   = 10'h2d5;
    localparam logic [9:0]   HOLDOVER_CH2_ADDR   = 10'h2d6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0]   LIMITER_SELECT_RST  = 6'h00;
    localparam logic [3:0]   HOLDOVER_CODE_RST   = 4'h0;
    localparam logic [7:0]   READ_IDLE_DATA      = 8'h00;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int           SEL_W               = 2;
    localparam int           SEL_CH0_LSB         = 0;
    localparam int           SEL_CH1_LSB         = 2;
    localparam int           SEL_CH2_LSB         = 4;
    localparam int           LIMITER_FIELD_W     = 6;
    localparam int           HOLDOVER_CODE_W     = 4;
    localparam logic [3:0]   HOLDOVER_BYPASS     = 4'h0;

    // ------------------------------------------------------------
    // Limiter selector encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LIMIT_AUTO     = 2'h0,
        LIMIT_OFF      = 2'h1,
        LIMIT_ON       = 2'h2,
        LIMIT_OFF_ALT  = 2'h3
    } limiter_sel_t;

    // ------------------------------------------------------------
    // Automatic mode threshold, bandwidth in millihertz
    // ------------------------------------------------------------
    localparam int           LOOP_BW_W           = 32;
    localparam logic [31:0]  AUTO_LIMIT_BW_MHZ   = 32'h0000_0064;

    // Holdover bandwidth numerator: BW = 343 / (2^n * 2 * pi) Hz
    localparam int           HOLDOVER_BW_NUM     = 343;

endpackage

/* src/limiter_channel.sv */
// Per-channel frequency change limiter mode decode
`timescale 1ns/100ps
`default_nettype none

module limiter_channel
(
    // Clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    // Configuration and loop state
    input  wire logic [dpll_cfg_pkg::SEL_W-1:0]       limiterSelect,
    input  wire logic [dpll_cfg_pkg::LOOP_BW_W-1:0]   loopBwMilliHz,
    // Limiter control
    output logic                                      limiterActive
);

    dpll_cfg_pkg::limiter_sel_t selMode;
    logic                       autoActive;

    assign selMode    = dpll_cfg_pkg::limiter_sel_t'(limiterSelect);
    // Active only for loop bandwidth at or below 0.1 Hz
    assign autoActive = (loopBwMilliHz <= dpll_cfg_pkg::AUTO_LIMIT_BW_MHZ);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            limiterActive <= 1'b0;
        end
        else
        begin
            case (selMode)
                dpll_cfg_pkg::LIMIT_AUTO:    limiterActive <= autoActive;
                dpll_cfg_pkg::LIMIT_ON:      limiterActive <= 1'b1;
                dpll_cfg_pkg::LIMIT_OFF:     limiterActive <= 1'b0;
                dpll_cfg_pkg::LIMIT_OFF_ALT: limiterActive <= 1'b0;
                default:                     limiterActive <= 1'b0;
            endcase
        end
    end

endmodule

`default_nettype wire

/* src/dpll_limiter_holdover_cfg.sv */
// Limiter select and holdover filter bandwidth registers for three DPLL channels
//
// Operation
// - Limiter register holds selectors: bits 5:4 ch2, 3:2 ch1, 1:0 ch0.
// - Automatic mode: limiter active only when loop bandwidth at or below 0.1 Hz.
// - Holdover register bits 3:0 select filter bandwidth; bits 7:4 reserved.
// - Holdover code zero, the reset value, bypasses the filter.
// - Nonzero code n gives bandwidth 343 / (2^n * 2 pi) Hz.
// - Three holdover registers at 0x2d4, 0x2d5, 0x2d6 for channels 0, 1, 2.
`timescale 1ns/100ps
`default_nettype none

module dpll_limiter_holdover_cfg
(
    // Clock and reset
    input  wire logic                                       clk,
    input  wire logic                                       rst,
    // Register access from the host interface
    input  wire logic [dpll_cfg_pkg::ADDR_W-1:0]            regAddr,
    input  wire logic                                       regWrEn,
    input  wire logic [dpll_cfg_pkg::DATA_W-1:0]            regWrData,
    input  wire logic                                       regRdEn,
    output logic      [dpll_cfg_pkg::DATA_W-1:0]            regRdData,
    output logic                                            regRdValid,
    // Loop bandwidth of each channel, millihertz
    input  wire logic [dpll_cfg_pkg::LOOP_BW_W-1:0]         loopBwMilliHzCh0,
    input  wire logic [dpll_cfg_pkg::LOOP_BW_W-1:0]         loopBwMilliHzCh1,
    input  wire logic [dpll_cfg_pkg::LOOP_BW_W-1:0]         loopBwMilliHzCh2,
    // Limiter controls
    output logic                                            limiterActiveCh0,
    output logic                                            limiterActiveCh1,
    output logic                                            limiterActiveCh2,
    // Holdover filter controls
    output logic      [dpll_cfg_pkg::HOLDOVER_CODE_W-1:0]   holdoverCodeCh0,
    output logic      [dpll_cfg_pkg::HOLDOVER_CODE_W-1:0]   holdoverCodeCh1,
    output logic      [dpll_cfg_pkg::HOLDOVER_CODE_W-1:0]   holdoverCodeCh2,
    output logic                                            holdoverBypassCh0,
    output logic                                            holdoverBypassCh1,
    output logic                                            holdoverBypassCh2
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [dpll_cfg_pkg::LIMITER_FIELD_W-1:0] limiterSelect_r;
    logic [dpll_cfg_pkg::HOLDOVER_CODE_W-1:0] holdoverCode_r [dpll_cfg_pkg::NUM_CH];
    logic [dpll_cfg_pkg::DATA_W-1:0]          rdData_nxt;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Zero code means the holdover filter is skipped
    function automatic logic codeIsBypass
    (
        input logic [dpll_cfg_pkg::HOLDOVER_CODE_W-1:0] code
    );
        return (code == dpll_cfg_pkg::HOLDOVER_BYPASS);
    endfunction

    // Reserved upper bits read back as zero
    function automatic logic [dpll_cfg_pkg::DATA_W-1:0] holdoverReadback
    (
        input logic [dpll_cfg_pkg::HOLDOVER_CODE_W-1:0] code
    );
        return {4'h0, code};
    endfunction

    logic selLimiter;
    logic selHold0;
    logic selHold1;
    logic selHold2;

    assign selLimiter = (regAddr == dpll_cfg_pkg::LIMITER_SELECT_ADDR);
    assign selHold0   = (regAddr == dpll_cfg_pkg::HOLDOVER_CH0_ADDR);
    assign selHold1   = (regAddr == dpll_cfg_pkg::HOLDOVER_CH1_ADDR);
    assign selHold2   = (regAddr == dpll_cfg_pkg::HOLDOVER_CH2_ADDR);

    // ------------------------------------------------------------
    // Limiter select register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            limiterSelect_r <= dpll_cfg_pkg::LIMITER_SELECT_RST;
        end
        else if (regWrEn && selLimiter)
        begin
            // Bits 7:6 reserved, dropped
            limiterSelect_r <= regWrData[dpll_cfg_pkg::LIMITER_FIELD_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Holdover filter registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < dpll_cfg_pkg::NUM_CH; i++)
            begin
                holdoverCode_r[i] <= dpll_cfg_pkg::HOLDOVER_CODE_RST;
            end
        end
        else if (regWrEn)
        begin
            // Upper nibble reserved, kept at zero
            if (selHold0)
            begin
                holdoverCode_r[0] <= regWrData[dpll_cfg_pkg::HOLDOVER_CODE_W-1:0];
            end
            if (selHold1)
            begin
                holdoverCode_r[1] <= regWrData[dpll_cfg_pkg::HOLDOVER_CODE_W-1:0];
            end
            if (selHold2)
            begin
                holdoverCode_r[2] <= regWrData[dpll_cfg_pkg::HOLDOVER_CODE_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    always_comb
    begin
        rdData_nxt = dpll_cfg_pkg::READ_IDLE_DATA;
        if (selLimiter)
        begin
            rdData_nxt = {2'h0, limiterSelect_r};
        end
        else if (selHold0)
        begin
            rdData_nxt = holdoverReadback(holdoverCode_r[0]);
        end
        else if (selHold1)
        begin
            rdData_nxt = holdoverReadback(holdoverCode_r[1]);
        end
        else if (selHold2)
        begin
            rdData_nxt = holdoverReadback(holdoverCode_r[2]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            regRdData  <= dpll_cfg_pkg::READ_IDLE_DATA;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRdEn;
            if (regRdEn)
            begin
                regRdData <= rdData_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // Holdover filter outputs
    // ------------------------------------------------------------
    // Code n divides 343/(2*pi) Hz by 2^n; codes and bypass flags registered here
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            holdoverCodeCh0   <= dpll_cfg_pkg::HOLDOVER_CODE_RST;
            holdoverCodeCh1   <= dpll_cfg_pkg::HOLDOVER_CODE_RST;
            holdoverCodeCh2   <= dpll_cfg_pkg::HOLDOVER_CODE_RST;
            holdoverBypassCh0 <= 1'b1;
            holdoverBypassCh1 <= 1'b1;
            holdoverBypassCh2 <= 1'b1;
        end
        else
        begin
            holdoverCodeCh0   <= holdoverCode_r[0];
            holdoverCodeCh1   <= holdoverCode_r[1];
            holdoverCodeCh2   <= holdoverCode_r[2];
            holdoverBypassCh0 <= codeIsBypass(holdoverCode_r[0]);
            holdoverBypassCh1 <= codeIsBypass(holdoverCode_r[1]);
            holdoverBypassCh2 <= codeIsBypass(holdoverCode_r[2]);
        end
    end

    // ------------------------------------------------------------
    // Limiter channels
    // ------------------------------------------------------------
    limiter_channel u_limiter_ch0
    (
        .clk           (clk),
        .rst           (rst),
        .limiterSelect (limiterSelect_r[dpll_cfg_pkg::SEL_CH0_LSB +: dpll_cfg_pkg::SEL_W]),
        .loopBwMilliHz (loopBwMilliHzCh0),
        .limiterActive (limiterActiveCh0)
    );

    limiter_channel u_limiter_ch1
    (
        .clk           (clk),
        .rst           (rst),
        .limiterSelect (limiterSelect_r[dpll_cfg_pkg::SEL_CH1_LSB +: dpll_cfg_pkg::SEL_W]),
        .loopBwMilliHz (loopBwMilliHzCh1),
        .limiterActive (limiterActiveCh1)
    );

    limiter_channel u_limiter_ch2
    (
        .clk           (clk),
        .rst           (rst),
        .limiterSelect (limiterSelect_r[dpll_cfg_pkg::SEL_CH2_LSB +: dpll_cfg_pkg::SEL_W]),
        .loopBwMilliHz (loopBwMilliHzCh2),
        .limiterActive (limiterActiveCh2)
    );

endmodule

`default_nettype wire

/* verif/dpll_limiter_holdover_cfg_asserts.sv */
// Assertions for the DPLL limiter and holdover configuration bank
`timescale 1ns/100ps
`default_nettype none
module dpll_limiter_holdover_cfg_asserts
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register access
    input wire logic [9:0]  regAddr,
    input wire logic        regWrEn,
    input wire logic [7:0]  regWrData,
    input wire logic        regRdEn,
    input wire logic [7:0]  regRdData,
    input wire logic        regRdValid,
    // Channel state
    input wire logic [31:0] loopBwMilliHzCh2,
    input wire logic        limiterActiveCh0,
    input wire logic        limiterActiveCh1,
    input wire logic        limiterActiveCh2,
    input wire logic [3:0]  holdoverCodeCh0,
    input wire logic [3:0]  holdoverCodeCh1,
    input wire logic [3:0]  holdoverCodeCh2,
    input wire logic        holdoverBypassCh0,
    input wire logic        holdoverBypassCh1,
    input wire logic        holdoverBypassCh2
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_selWr(int sh, logic [1:0] v);
        regWrEn && regAddr == dpll_cfg_pkg::LIMITER_SELECT_ADDR && regWrData[sh+:2] == v;
    endsequence
    property p_rdValid;
        regRdEn |=> regRdValid;
    endproperty
    property p_noRdValid;
        !regRdEn |=> !regRdValid;
    endproperty
    property p_unmapRd;
        regRdEn && !(regAddr inside {10'h2cf, 10'h2d4, 10'h2d5, 10'h2d6}) |=> regRdData == 8'h00;
    endproperty
    property p_bypass;
        holdoverBypassCh0 == (holdoverCodeCh0 == 4'h0) && holdoverBypassCh1 == (holdoverCodeCh1
            == 4'h0) && holdoverBypassCh2 == (holdoverCodeCh2 == 4'h0);
    endproperty
    property p_hoCh0;
        regWrEn && regAddr == dpll_cfg_pkg::HOLDOVER_CH0_ADDR
            |-> ##2 holdoverCodeCh0 == $past(regWrData[3:0], 2);
    endproperty
    property p_hoCh2;
        regWrEn && regAddr == dpll_cfg_pkg::HOLDOVER_CH2_ADDR
            |-> ##2 holdoverCodeCh2 == $past(regWrData[3:0], 2);
    endproperty
    property p_forceOn;
        s_selWr(0, 2'h2) |-> ##2 limiterActiveCh0;
    endproperty
    property p_forceOff;
        regWrEn && regAddr == dpll_cfg_pkg::LIMITER_SELECT_ADDR && regWrData[2] |-> ##2 !limiterActiveCh1;
    endproperty
    property p_auto;
        s_selWr(4, 2'h0) |-> ##2 limiterActiveCh2 == ($past(loopBwMilliHzCh2) <= 32'h0000_0064);
    endproperty
    a_rdValid: assert property (p_rdValid) else $error("read not answered");
    a_noRdValid: assert property (p_noRdValid) else $error("stray read valid");
    a_unmapRd: assert property (p_unmapRd) else $error("unmapped read not zero");
    a_bypass: assert property (p_bypass) else $error("bypass mismatch");
    a_hoCh0: assert property (p_hoCh0) else $error("ch0 holdover code wrong");
    a_hoCh2: assert property (p_hoCh2) else $error("ch2 holdover code wrong");
    a_forceOn: assert property (p_forceOn) else $error("forced on not active");
    a_forceOff: assert property (p_forceOff) else $error("forced off active");
    a_auto: assert property (p_auto) else $error("auto limiter wrong");
endmodule
bind dpll_limiter_holdover_cfg dpll_limiter_holdover_cfg_asserts i_dpll_limiter_holdover_cfg_asserts
(
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .loopBwMilliHzCh2(loopBwMilliHzCh2), .limiterActiveCh0(limiterActiveCh0),
    .limiterActiveCh1(limiterActiveCh1), .limiterActiveCh2(limiterActiveCh2),
    .holdoverCodeCh0(holdoverCodeCh0), .holdoverCodeCh1(holdoverCodeCh1),
    .holdoverCodeCh2(holdoverCodeCh2), .holdoverBypassCh0(holdoverBypassCh0),
    .holdoverBypassCh1(holdoverBypassCh1), .holdoverBypassCh2(holdoverBypassCh2)
);
`default_nettype wire

/* verif/dpll_limiter_holdover_cfg_test.sv */
// Self-checking testbench for the DPLL limiter and holdover configuration bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module dpll_limiter_holdover_cfg_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  regAddr = 10'h000;
    logic        regWrEn = 1'b0;
    logic [7:0]  regWrData = 8'h00;
    logic        regRdEn = 1'b0;
    logic [7:0]  regRdData;
    logic        regRdValid;
    logic [31:0] bw [3] = '{32'h0, 32'h0, 32'h0};
    wire logic [2:0]  act;
    wire logic [3:0]  code [3];
    wire logic [2:0]  byp;
    logic [7:0]  sel;
    int          errors = 0;
    int          n_tests = 0;

    always #2 clk = ~clk;

    dpll_limiter_holdover_cfg i_dpll_limiter_holdover_cfg
    (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .loopBwMilliHzCh0(bw[0]), .loopBwMilliHzCh1(bw[1]), .loopBwMilliHzCh2(bw[2]),
        .limiterActiveCh0(act[0]), .limiterActiveCh1(act[1]), .limiterActiveCh2(act[2]),
        .holdoverCodeCh0(code[0]), .holdoverCodeCh1(code[1]), .holdoverCodeCh2(code[2]),
        .holdoverBypassCh0(byp[0]), .holdoverBypassCh1(byp[1]), .holdoverBypassCh2(byp[2])
    );

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        `CHK("regRdValid", 1'b1, regRdValid)
        `CHK("regRdData", e, regRdData)
    endtask

    function automatic logic expAct(input logic [1:0] v, input logic [31:0] b);
        return v == 2'h2 || (v == 2'h0 && b <= 32'h0000_0064);
    endfunction

    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(dpll_cfg_pkg::LIMITER_SELECT_ADDR, 8'h00);
        for (int c = 0; c < 3; c++)
        begin
            rd(dpll_cfg_pkg::HOLDOVER_CH0_ADDR + 10'(c), 8'h00);
            `CHK("holdoverBypass", 1'b1, byp[c])
        end
        for (int v = 0; v < 4; v++)
            for (int b = 0; b < 2; b++)
            begin
                @(posedge clk);
                for (int c = 0; c < 3; c++)
                    bw[c] <= 32'(100 + b - c + 2 * c * b);
                sel = {2'h3, 2'(v + 2), 2'(v + 1), 2'(v)};
                wr(dpll_cfg_pkg::LIMITER_SELECT_ADDR, sel);
                rd(dpll_cfg_pkg::LIMITER_SELECT_ADDR, {2'h0, sel[5:0]});
                for (int c = 0; c < 3; c++)
                    `CHK("limiterActive", expAct(sel[2*c+:2], bw[c]), act[c])
            end
        for (int n = 0; n < 16; n++)
        begin
            for (int c = 0; c < 3; c++)
            begin
                wr(dpll_cfg_pkg::HOLDOVER_CH0_ADDR + 10'(c), {4'ha, 4'(n + c)});
                rd(dpll_cfg_pkg::HOLDOVER_CH0_ADDR + 10'(c), {4'h0, 4'(n + c)});
            end
            for (int c = 0; c < 3; c++)
            begin
                `CHK("holdoverCode", 4'(n + c), code[c])
                `CHK("holdoverBypass", 4'(n + c) == 4'h0, byp[c])
            end
        end
        wr(10'h2d7, 8'hff);
        rd(10'h2d7, 8'h00);
        rd(10'h2d3, 8'h00);
        rd(dpll_cfg_pkg::HOLDOVER_CH2_ADDR, 8'h01);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(dpll_cfg_pkg::LIMITER_SELECT_ADDR, 8'h00);
        rd(dpll_cfg_pkg::HOLDOVER_CH0_ADDR, 8'h00);
        `CHK("limiterActive", 3'h0, act)
        `CHK("holdoverBypass", 3'h7, byp)
        `CHK("holdoverCode", 4'h0, code[2])
        report_and_stop();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
